/* File: common/ssbp_pkg.sv */
package ssbp_pkg;

  // register byte addresses
  localparam logic [11:0] SSBP_OFS_CTL = 12'hcd0;
  localparam logic [11:0] SSBP_OFS_TX = 12'hcd1;
  localparam logic [11:0] SSBP_OFS_CMD = 12'hcd2;
  localparam logic [11:0] SSBP_OFS_STA = 12'hcd3;
  localparam logic [11:0] SSBP_OFS_RX = 12'hcd4;

  // reset values
  localparam logic [7:0] SSBP_RST_CTL = 8'h00;
  localparam logic [7:0] SSBP_RST_TX = 8'h00;
  localparam logic [1:0] SSBP_RST_CMD = 2'h0;
  localparam logic [7:0] SSBP_RST_RX = 8'h00;

  // control field positions
  localparam int SSBP_CTL_MSB_BIT = 0;
  localparam int SSBP_CTL_IDLE_LOW_BIT = 1;
  localparam int SSBP_CTL_PHASE_BIT = 2;
  localparam int SSBP_CTL_IRQ_EN_BIT = 3;
  localparam int SSBP_CTL_SEL_LSB = 4;
  localparam int SSBP_CTL_SEL_MSB = 6;
  localparam logic [7:0] SSBP_CTL_MASK = 8'h7f;

  // status field positions
  localparam int SSBP_STA_DONE_BIT = 0;
  localparam int SSBP_STA_BUSY_BIT = 1;

  // command codes
  localparam logic [1:0] SSBP_CMD_RSVD = 2'h0;
  localparam logic [1:0] SSBP_CMD_TX = 2'h1;
  localparam logic [1:0] SSBP_CMD_RX = 2'h2;
  localparam logic [1:0] SSBP_CMD_TRX = 2'h3;

  // timing counts
  localparam logic [4:0] SSBP_LAST_EDGE = 5'h10;
  localparam logic [8:0] SSBP_HALF_BASE = 9'h002;
  localparam logic [1:0] SSBP_TAIL_TX = 2'h2;
  localparam logic [1:0] SSBP_TAIL_RX = 2'h1;

  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_TAIL, ST_GAP} ssbp_state_type;

  // position of the n-th bit on the wire within the byte
  function automatic logic [2:0] ssbp_bit_index(input logic [2:0] n, input logic msb_first);
    return msb_first ? 3'h7 - n : n;
  endfunction

  // system clocks per half serial period, minus one
  function automatic logic [7:0] ssbp_half_limit(input logic [2:0] sel);
    logic [8:0] half;
    half = SSBP_HALF_BASE << sel;
    return 8'(half - 9'h001);
  endfunction

  // half periods between last clock edge and completion
  function automatic logic [1:0] ssbp_tail(input logic [1:0] cmd, input logic phase_swap);
    logic [1:0] t;
    t = cmd[0] ? SSBP_TAIL_TX : SSBP_TAIL_RX;
    return phase_swap ? t - 2'h1 : t;
  endfunction

endpackage

/* File: common/ssbp_tick_if.sv */
`timescale 1ns/100ps
interface ssbp_tick_if;
  logic run;
  logic [2:0] sel;
  logic tick;
  modport engine (output run, output sel, input tick);
  modport divider (input run, input sel, output tick);
endinterface

/* File: hdl/ssbp_divider.sv */
`timescale 1ns/100ps
module ssbp_divider
  import ssbp_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  ssbp_tick_if.divider tk
);

  logic [7:0] cnt_reg;
  logic tick_reg;

  // one pulse per half serial period while running, phase restarts with run
  always_ff @(posedge mclk) begin
    if (srst || !tk.run) begin
      cnt_reg <= 8'h00;
      tick_reg <= 1'b0;
    end else if (cnt_reg == ssbp_half_limit(tk.sel)) begin
      cnt_reg <= 8'h00;
      tick_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
      tick_reg <= 1'b0;
    end
  end

  assign tk.tick = tick_reg;

  property p_div_spacing;
    @(posedge mclk) disable iff (srst)
    tick_reg && tk.run && $stable(tk.sel) |=> !tick_reg;
  endproperty
  a_div_spacing: assert property (p_div_spacing) else $error("divider ticks back to back");

endmodule

/* File: hdl/ssbp_top.sv */
// How it works
// - irq request while done flag and enabled
// - phase 0: drive odd edges, sample even
// - phase 0: sample edges 2-16, half-period tail on rx, full-period tail when transmitting
// - phase 1: first bit early, sample odd edges
// - phase 1: rx completes at last clock transition, transmit half a period later
// - polarity bit picks idle level, eight pulses
// - bit order select applies to both directions
// - transmit byte survives transmission
// - command 01 tx, 10 rx, 11 both
// - command field reads last written code
// - transfer starts only after command write
// - at least two idle system clocks (gap, then idle) between transfers
// - busy set by command, cleared at end
// - done flag sticky, cleared by writing one
// - flags settle zero, half or full period late
// - receive byte holds last received, read-only
// - serial clock divisor 4 to 512
`timescale 1ns/100ps
module ssbp_top
  import ssbp_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic serial_clock_out,
  output logic serial_data_out,
  input wire logic serial_data_in,
  output logic irq_request
);

  ssbp_tick_if tk ();

  logic [7:0] serial_port_control_reg;
  logic [7:0] serial_tx_byte_reg;
  logic [1:0] serial_command_reg;
  logic [7:0] serial_rx_byte_reg;
  logic port_active_reg;
  logic done_flag_reg;
  logic start_pend_reg;
  logic [7:0] rdata_reg;
  logic irq_reg;
  logic di_meta_reg;
  logic di_sync_reg;
  ssbp_state_type state_reg;
  logic [4:0] edge_reg;
  logic [1:0] tail_reg;
  logic [1:0] mode_cmd_reg;
  logic mode_phase_reg;
  logic mode_msb_reg;
  logic [7:0] rx_shift_reg;
  logic sclk_reg;
  logic dout_reg;
  logic run_reg;

  logic wr_ctl, wr_tx, wr_cmd, wr_sta;
  logic cmd_go;
  logic ev;
  logic [4:0] edge_next;
  logic sample_now, drive_now;
  logic [2:0] drive_n, sample_n;
  logic finish;

  assign wr_ctl = reg_wr && reg_addr == SSBP_OFS_CTL;
  assign wr_tx = reg_wr && reg_addr == SSBP_OFS_TX;
  assign wr_cmd = reg_wr && reg_addr == SSBP_OFS_CMD;
  assign wr_sta = reg_wr && reg_addr == SSBP_OFS_STA;
  assign cmd_go = wr_cmd && reg_wdata[1:0] != SSBP_CMD_RSVD;

  ssbp_divider u_div (
    .mclk(mclk),
    .srst(srst),
    .tk(tk)
  );

  assign tk.run = run_reg;
  assign tk.sel = serial_port_control_reg[SSBP_CTL_SEL_MSB:SSBP_CTL_SEL_LSB];

  // edge bookkeeping: edges are numbered 1..16 from the start of the transfer
  assign ev = tk.tick && state_reg == ST_SHIFT;
  assign edge_next = edge_reg + 5'h01;
  assign sample_now = ev && mode_cmd_reg[1] && (edge_next[0] == mode_phase_reg);
  assign drive_now = ev && mode_cmd_reg[0] && (edge_next[0] != mode_phase_reg)
                     && edge_next != SSBP_LAST_EDGE;
  assign sample_n = 3'((edge_next - 5'h01) >> 1);
  assign drive_n = mode_phase_reg ? 3'(edge_next >> 1) : sample_n;
  assign finish = (ev && edge_next == SSBP_LAST_EDGE && ssbp_tail(mode_cmd_reg, mode_phase_reg) == 2'h0)
                  || (state_reg == ST_TAIL && tk.tick && tail_reg == 2'h1);

  always_ff @(posedge mclk) begin
    if (srst) begin
      di_meta_reg <= 1'b0;
      di_sync_reg <= 1'b0;
    end else begin
      di_meta_reg <= serial_data_in;
      di_sync_reg <= di_meta_reg;
    end
  end

  // software-written registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      serial_port_control_reg <= SSBP_RST_CTL;
      serial_tx_byte_reg <= SSBP_RST_TX;
      serial_command_reg <= SSBP_RST_CMD;
    end else begin
      if (wr_ctl) begin
        serial_port_control_reg <= reg_wdata & SSBP_CTL_MASK;
      end
      if (wr_tx) begin
        serial_tx_byte_reg <= reg_wdata;
      end
      if (wr_cmd) begin
        serial_command_reg <= reg_wdata[1:0];
      end
    end
  end

  // status flags, a set wins over a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      port_active_reg <= 1'b0;
      done_flag_reg <= 1'b0;
      start_pend_reg <= 1'b0;
    end else begin
      if (cmd_go) begin
        port_active_reg <= 1'b1;
      end else if (finish) begin
        port_active_reg <= 1'b0;
      end
      if (finish) begin
        done_flag_reg <= 1'b1;
      end else if (wr_sta && reg_wdata[SSBP_STA_DONE_BIT]) begin
        done_flag_reg <= 1'b0;
      end
      if (cmd_go) begin
        start_pend_reg <= 1'b1;
      end else if (state_reg == ST_IDLE) begin
        start_pend_reg <= 1'b0;
      end
    end
  end

  // transfer sequencer
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      edge_reg <= 5'h00;
      tail_reg <= 2'h0;
      mode_cmd_reg <= SSBP_CMD_RSVD;
      mode_phase_reg <= 1'b0;
      mode_msb_reg <= 1'b0;
      run_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (start_pend_reg) begin
            state_reg <= ST_SHIFT;
            edge_reg <= 5'h00;
            mode_cmd_reg <= serial_command_reg;
            mode_phase_reg <= serial_port_control_reg[SSBP_CTL_PHASE_BIT];
            mode_msb_reg <= serial_port_control_reg[SSBP_CTL_MSB_BIT];
            run_reg <= 1'b1;
          end
        end
        ST_SHIFT: begin
          if (ev) begin
            edge_reg <= edge_next;
            if (finish) begin
              state_reg <= ST_GAP;
              run_reg <= 1'b0;
            end else if (edge_next == SSBP_LAST_EDGE) begin
              state_reg <= ST_TAIL;
              tail_reg <= ssbp_tail(mode_cmd_reg, mode_phase_reg);
            end
          end
        end
        ST_TAIL: begin
          if (tk.tick) begin
            tail_reg <= tail_reg - 2'h1;
            if (finish) begin
              state_reg <= ST_GAP;
              run_reg <= 1'b0;
            end
          end
        end
        ST_GAP: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // serial clock and data pins
  always_ff @(posedge mclk) begin
    if (srst) begin
      sclk_reg <= 1'b1;
    end else if (state_reg == ST_IDLE || state_reg == ST_GAP) begin
      sclk_reg <= !serial_port_control_reg[SSBP_CTL_IDLE_LOW_BIT];
    end else if (ev) begin
      sclk_reg <= !sclk_reg;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      dout_reg <= 1'b0;
    end else if (state_reg == ST_IDLE && start_pend_reg) begin
      if (serial_command_reg == SSBP_CMD_RX) begin
        dout_reg <= 1'b0;
      end else if (serial_port_control_reg[SSBP_CTL_PHASE_BIT]) begin
        dout_reg <= serial_tx_byte_reg[ssbp_bit_index(3'h0, serial_port_control_reg[SSBP_CTL_MSB_BIT])];
      end
    end else if (drive_now) begin
      dout_reg <= serial_tx_byte_reg[ssbp_bit_index(drive_n, mode_msb_reg)];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rx_shift_reg <= SSBP_RST_RX;
      serial_rx_byte_reg <= SSBP_RST_RX;
    end else begin
      if (sample_now) begin
        rx_shift_reg[ssbp_bit_index(sample_n, mode_msb_reg)] <= di_sync_reg;
      end
      if (finish && mode_cmd_reg[1]) begin
        serial_rx_byte_reg <= rx_shift_reg;
      end
    end
  end

  // register read port, registered one cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        SSBP_OFS_CTL: rdata_reg <= serial_port_control_reg;
        SSBP_OFS_TX: rdata_reg <= serial_tx_byte_reg;
        SSBP_OFS_CMD: rdata_reg <= {6'h00, serial_command_reg};
        SSBP_OFS_STA: rdata_reg <= {6'h00, port_active_reg, done_flag_reg};
        SSBP_OFS_RX: rdata_reg <= serial_rx_byte_reg;
        default: rdata_reg <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= done_flag_reg && serial_port_control_reg[SSBP_CTL_IRQ_EN_BIT];
    end
  end

  assign reg_rdata = rdata_reg;
  assign serial_clock_out = sclk_reg;
  assign serial_data_out = dout_reg;
  assign irq_request = irq_reg;

  property p_irq;
    @(posedge mclk) disable iff (srst)
    done_flag_reg && serial_port_control_reg[SSBP_CTL_IRQ_EN_BIT] |=> irq_request;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");

  property p_no_irq;
    @(posedge mclk) disable iff (srst)
    !serial_port_control_reg[SSBP_CTL_IRQ_EN_BIT] |=> !irq_request;
  endproperty
  a_no_irq: assert property (p_no_irq) else $error("irq while disabled");

  property p_idle_level;
    @(posedge mclk) disable iff (srst)
    state_reg == ST_IDLE && $past(state_reg) == ST_IDLE && $stable(serial_port_control_reg)
      |-> serial_clock_out == !serial_port_control_reg[SSBP_CTL_IDLE_LOW_BIT];
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("wrong idle clock level");

  property p_busy_set;
    @(posedge mclk) disable iff (srst)
    cmd_go |=> port_active_reg;
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy not set");

  property p_rsvd_cmd;
    @(posedge mclk) disable iff (srst)
    wr_cmd && reg_wdata[1:0] == SSBP_CMD_RSVD && !port_active_reg |=> !port_active_reg ##1 state_reg == ST_IDLE;
  endproperty
  a_rsvd_cmd: assert property (p_rsvd_cmd) else $error("reserved command started");

  property p_done_sticky;
    @(posedge mclk) disable iff (srst)
    done_flag_reg && !(wr_sta && reg_wdata[SSBP_STA_DONE_BIT]) |=> done_flag_reg;
  endproperty
  a_done_sticky: assert property (p_done_sticky) else $error("done flag lost");

  property p_gap;
    @(posedge mclk) disable iff (srst)
    finish |=> state_reg == ST_GAP && !port_active_reg || cmd_go ##1 state_reg == ST_IDLE;
  endproperty
  a_gap: assert property (p_gap) else $error("no idle gap");

  property p_phase0_tail;
    @(posedge mclk) disable iff (srst)
    ev && edge_next == SSBP_LAST_EDGE && !mode_phase_reg |=> state_reg == ST_TAIL && !port_active_reg == 1'b0;
  endproperty
  a_phase0_tail: assert property (p_phase0_tail) else $error("phase 0 ended on last edge");

  property p_phase1_rx_end;
    @(posedge mclk) disable iff (srst)
    ev && edge_next == SSBP_LAST_EDGE && mode_phase_reg && mode_cmd_reg == SSBP_CMD_RX
      |=> state_reg == ST_GAP && done_flag_reg;
  endproperty
  a_phase1_rx_end: assert property (p_phase1_rx_end) else $error("phase 1 receive not done at last edge");

  property p_rx_commit;
    @(posedge mclk) disable iff (srst)
    finish && mode_cmd_reg[1] |=> serial_rx_byte_reg == $past(rx_shift_reg);
  endproperty
  a_rx_commit: assert property (p_rx_commit) else $error("receive byte not stored");

  property p_rx_quiet;
    @(posedge mclk) disable iff (srst)
    state_reg == ST_SHIFT && mode_cmd_reg == SSBP_CMD_RX |-> !serial_data_out;
  endproperty
  a_rx_quiet: assert property (p_rx_quiet) else $error("data out moved in receive");

  property p_tx_keep;
    @(posedge mclk) disable iff (srst)
    finish && !wr_tx |=> serial_tx_byte_reg == $past(serial_tx_byte_reg);
  endproperty
  a_tx_keep: assert property (p_tx_keep) else $error("transmit byte changed");

  c_tx: cover property (@(posedge mclk) disable iff (srst) finish && mode_cmd_reg == SSBP_CMD_TX);
  c_rx: cover property (@(posedge mclk) disable iff (srst) finish && mode_cmd_reg == SSBP_CMD_RX);
  c_trx_swap: cover property (@(posedge mclk) disable iff (srst)
    finish && mode_cmd_reg == SSBP_CMD_TRX && mode_phase_reg && mode_msb_reg);
  c_back_to_back: cover property (@(posedge mclk) disable iff (srst) finish ##[1:3] cmd_go);

endmodule

/* File: verif/ssbp_peer_model.sv */
`timescale 1ns/100ps
module ssbp_peer_model (
  input wire logic serial_clock_out,
  input wire logic serial_data_out,
  input wire logic arm,
  input wire logic phase,
  input wire logic msb,
  input wire logic [7:0] peer_byte,
  output logic serial_data_in,
  output logic [7:0] cap_byte,
  output int edges,
  output realtime last_t,
  output realtime gap
);
  function automatic int pos(input int n);
    return msb ? 7 - n : n;
  endfunction
  initial begin
    serial_data_in = 1'b0;
    cap_byte = 8'h00;
    edges = 0;
    last_t = 0;
    gap = 0;
  end
  // first bit stands before the first edge in either phase
  always @(posedge arm) begin
    edges = 0;
    cap_byte = 8'h00;
    serial_data_in = peer_byte[pos(0)];
  end
  // released line shows the inverse of its last value
  always @(negedge arm) serial_data_in = ~serial_data_in;
  always @(serial_clock_out) begin
    if (arm) begin
      edges = edges + 1;
      if (edges > 1) gap = $realtime - last_t;
      last_t = $realtime;
      if (edges <= 16 && edges[0] == phase) cap_byte[pos((edges - 1) >> 1)] = serial_data_out;
      if (edges >= 2 && edges <= 15 && edges[0] != phase) serial_data_in = peer_byte[pos(edges >> 1)];
      if (edges == 16) serial_data_in = ~serial_data_in;
    end
  end
endmodule

/* File: verif/testbench.sv */
`timescale 1ns/100ps
module testbench
  import ssbp_pkg::*;
;
  logic mclk, srst, reg_wr, reg_rd, irq_request;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, peer_byte, cap_byte;
  logic serial_clock_out, serial_data_out, serial_data_in;
  logic arm, phase, msb, irq_seen;
  int edges, err_total, checked;
  realtime last_t, gap, t_irq;

  ssbp_top dut_u (.mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_clock_out(serial_clock_out),
    .serial_data_out(serial_data_out), .serial_data_in(serial_data_in), .irq_request(irq_request));
  ssbp_peer_model peer_u (.serial_clock_out(serial_clock_out), .serial_data_out(serial_data_out),
    .arm(arm), .phase(phase), .msb(msb), .peer_byte(peer_byte), .serial_data_in(serial_data_in),
    .cap_byte(cap_byte), .edges(edges), .last_t(last_t), .gap(gap));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge irq_request) begin
    irq_seen = 1'b1;
    t_irq = $realtime;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    d = reg_rdata;
  endtask
  task automatic rchk(input string n, input logic [11:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(n, e, d);
  endtask

  initial begin
    #360000;
    err_total++;
    report_and_stop();
  end

  initial begin
    logic [7:0] d, tx, ctl, cmd;
    logic [7:0] rx_q[$];
    int h, sel, tail, dl, n;
    srst = 1'b1;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    arm = 1'b0;
    phase = 1'b0;
    msb = 1'b0;
    peer_byte = 8'h00;
    irq_seen = 1'b0;
    err_total = 0;
    checked = 0;
    rx_q.push_back(SSBP_RST_RX);
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    void'($urandom(32'hbde3011a));
    chk("idle clock", 8'h01, {7'h00, serial_clock_out});
    for (int a = 0; a < 6; a++) rchk("reset value", SSBP_OFS_CTL + 12'(a), 8'h00);
    wr(12'hcd5, 8'hff);
    rchk("unmapped", 12'hcd5, 8'h00);
    wr(SSBP_OFS_STA, 8'h03);
    rchk("status write", SSBP_OFS_STA, 8'h00);
    wr(SSBP_OFS_RX, 8'h5a);
    rchk("rx write", SSBP_OFS_RX, 8'h00);
    for (int i = 0; i < 14; i++) begin
      cmd = 8'((i + 1) % 4);
      sel = (i == 0) ? 7 : (cmd == 8'(SSBP_CMD_TX)) ? $urandom % 7 : 1 + $urandom % 6;
      h = 2 << sel;
      // phase bit follows the loop count so every command meets both phases
      ctl = {1'b0, 3'(sel), 1'($urandom), 3'(i >> 1) ^ 3'($urandom % 4)};
      tx = 8'($urandom);
      peer_byte <= 8'($urandom);
      phase <= ctl[SSBP_CTL_PHASE_BIT];
      msb <= ctl[SSBP_CTL_MSB_BIT];
      wr(SSBP_OFS_CTL, ctl);
      rchk("control", SSBP_OFS_CTL, ctl);
      arm <= 1'b1;
      wr(SSBP_OFS_TX, tx);
      chk("edges before command", 8'h00, 8'(edges));
      irq_seen = 1'b0;
      wr(SSBP_OFS_CMD, cmd);
      rchk("busy", SSBP_OFS_STA, (cmd == 8'h00) ? 8'h00 : 8'h02);
      n = 0;
      d = 8'h02;
      while (d[SSBP_STA_BUSY_BIT] !== 1'b0 && n < 3000) begin
        rd(SSBP_OFS_STA, d);
        n++;
      end
      chk("poll bound", 8'h01, 8'(n < 3000));
      chk("status at end", (cmd == 8'h00) ? 8'h00 : 8'h01, d);
      chk("irq level", 8'(ctl[SSBP_CTL_IRQ_EN_BIT] && cmd != 8'h00), {7'h00, irq_request});
      tail = (cmd == 8'(SSBP_CMD_RX)) ? 1 : 2;
      if (phase) tail--;
      if (irq_seen === 1'b1) begin
        dl = int'((t_irq - last_t) / 4.0);
        chk("completion delay", 8'h01, 8'(dl >= tail * h + 1 && dl <= tail * h + 3));
      end
      chk("clock edges", (cmd == 8'h00) ? 8'h00 : 8'h10, 8'(edges));
      chk("idle level", {7'h00, ~ctl[SSBP_CTL_IDLE_LOW_BIT]}, {7'h00, serial_clock_out});
      if (cmd != 8'h00) chk("half period", 8'(h / 2), 8'(int'(gap / 8.0)));
      chk("peer captured", cmd[0] ? tx : 8'h00, cap_byte);
      if (cmd[1]) rx_q.push_back(peer_byte);
      if (rx_q.size() > 1) void'(rx_q.pop_front());
      arm <= 1'b0;
      rchk("rx byte", SSBP_OFS_RX, rx_q[0]);
      rchk("tx kept", SSBP_OFS_TX, tx);
      rchk("command", SSBP_OFS_CMD, cmd);
      wr(SSBP_OFS_STA, 8'h00);
      rchk("done kept", SSBP_OFS_STA, (cmd == 8'h00) ? 8'h00 : 8'h01);
      wr(SSBP_OFS_STA, 8'h01);
      rchk("done cleared", SSBP_OFS_STA, 8'h00);
      chk("irq after clear", 8'h00, {7'h00, irq_request});
    end
    report_and_stop();
  end
endmodule
